// file: dv/ext_irq_checker.sv
// Purpose: Port-level checks of the interrupt bit block
// Assumes: One clock, synchronous active-high reset
// Notes:   Internal enables are unseen, so checks stay at the ports
`timescale 1ns/100ps
`default_nettype none
module ext_irq_checker (
  // Clock and reset
  input wire logic                  sys_clk_in,
  input wire logic                  rst_in,
  input wire logic                  clk_en_in,
  // Bus, events, receive byte stream and station address
  input wire ext_irq_pkg::apb_req_t apb_req_in,
  input wire ext_irq_pkg::apb_rsp_t apb_rsp_out,
  input wire ext_irq_pkg::events_t  events_in,
  input wire logic                  parity_response_enable_in,
  input wire ext_irq_pkg::rx_byte_t rx_byte_in,
  input wire logic [47:0]           station_phys_addr_in,
  // Design outputs
  input wire logic                  rx_auto_strip_out,
  input wire logic                  stop_out,
  input wire logic                  wake_frame_out,
  input wire logic                  irq_out_n
);
  import ext_irq_pkg::*;
  wire logic wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && clk_en_in;
  wire logic err = clk_en_in && (events_in.pci_data_parity || events_in.pci_master_abort
                   || events_in.pci_target_abort);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  rst_irq_a: assert property ($fell(rst_in) |-> irq_out_n)
    else $error("interrupt active after reset");
  rst_bits_a: assert property ($fell(rst_in) |-> !rx_auto_strip_out && !wake_frame_out && stop_out)
    else $error("control levels wrong after reset");
  strip_set_a: assert property (wr && apb_req_in.paddr == 8'h10 |=>
    rx_auto_strip_out == $past(apb_req_in.pwdata[10])) else $error("auto strip not written");
  // Soft reset lands one cycle late, hence depth two
  strip_hold_a: assert property ($changed(rx_auto_strip_out) |-> $past(wr) || $past(wr, 2))
    else $error("auto strip changed without a write");
  sys_stop_a: assert property (err |=> stop_out)
    else $error("system error did not stop");
  wake_rise_a: assert property ($rose(wake_frame_out) |-> $past(rx_byte_in.valid))
    else $error("wake without a received byte");
  wake_fall_a: assert property ($fell(wake_frame_out) |-> $past(wr) || $past(wr, 2))
    else $error("wake flag cleared without a write");
  err_phase_a: assert property (apb_rsp_out.pslverr |-> apb_req_in.psel && apb_req_in.penable)
    else $error("slave error outside access phase");
  zero_wait_a: assert property (apb_req_in.psel && apb_req_in.penable |-> apb_rsp_out.pready)
    else $error("access phase stretched");

  cover property (err);
  cover property ($rose(wake_frame_out));
  cover property (!irq_out_n);
  cover property (apb_rsp_out.pslverr);
endmodule : ext_irq_checker

bind ext_control_interrupt_bits ext_irq_checker i_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out), .events_in(events_in), .parity_response_enable_in(parity_response_enable_in),
  .rx_byte_in(rx_byte_in), .station_phys_addr_in(station_phys_addr_in), .rx_auto_strip_out(rx_auto_strip_out),
  .stop_out(stop_out), .wake_frame_out(wake_frame_out), .irq_out_n(irq_out_n));
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Directed bench for the interrupt bit block
// Assumes: Zero-wait APB, events as one-cycle pulses
// Notes:   Clock enable dropped once, to show that events are lost while frozen
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ext_irq_pkg::*;
  logic        clk     = 1'h0;
  logic        rst     = 1'h1;
  logic        pre     = 1'h0;
  logic        ce      = 1'h1;
  logic [47:0] sta     = 48'h5f4e3d2c1b0a;
  apb_req_t    req     = '0;
  events_t     evs     = '0;
  rx_byte_t    rx      = '0;
  apb_rsp_t    rsp;
  logic        strip;
  logic        stp;
  logic        wake;
  logic        irqn;
  int          errors  = 0;
  int          n_tests = 0;

  always #2.5 clk = ~clk;

  ext_control_interrupt_bits i_dut (
    .sys_clk_in(clk), .rst_in(rst), .clk_en_in(ce), .apb_req_in(req), .apb_rsp_out(rsp),
    .events_in(evs), .parity_response_enable_in(pre), .rx_byte_in(rx), .station_phys_addr_in(sta),
    .rx_auto_strip_out(strip), .stop_out(stp), .wake_frame_out(wake), .irq_out_n(irqn));

  task automatic final_report;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    req <= '{psel:1'h1, penable:1'h0, pwrite:w, paddr:a, pwdata:d};
    @(posedge clk);
    req.penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'h1 && k < 16);
    if (k >= 16) begin
      errors++;
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rc

  task automatic pulse(input events_t e);
    @(posedge clk);
    evs <= e;
    @(posedge clk);
    evs <= '0;
  endtask : pulse

  task automatic ci(input logic e);
    @(posedge clk);
    chk(32'(irqn), 32'(e));
  endtask : ci

  task automatic cw(input logic e);
    @(posedge clk);
    chk(32'(wake), 32'(e));
  endtask : cw

  task automatic frame(input logic [47:0] d, input int n);
    for (int i = 0; i < 6 + 6 * n; i++) begin
      @(posedge clk);
      rx <= '{sof:(i == 0), valid:1'h1, eof:1'h0, data:(i < 6) ? d[8*i+:8] : sta[8*(i%6)+:8]};
    end
    @(posedge clk);
    rx <= '{sof:1'h0, valid:1'h1, eof:1'h1, data:8'h00};
    @(posedge clk);
    rx <= '0;
  endtask : frame

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rc(8'h00, 32'h4);
    rc(8'h10, 32'h4);
    rc(8'h14, 32'h0);
    rc(8'h18, 32'h0);
    apb(1'h0, 8'h1c, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    ci(1'h1);
  endtask : t_reset

  task automatic t_bits;
    wr(8'h10, 32'hffffffff);
    wr(8'h14, 32'hffffffff);
    rc(8'h10, 32'h404);
    rc(8'h14, 32'h5420);
    wr(8'h00, 32'h4);
    rc(8'h10, 32'h404);
    rc(8'h14, 32'h5420);
    chk(32'(strip), 32'h1);
    wr(8'h14, 32'h0);
  endtask : t_bits

  task automatic t_begun;
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h40);
    pulse(events_t'(7'h40));
    rc(8'h10, 32'h8);
    ci(1'h0);
    wr(8'h10, 32'h4);
    ci(1'h1);
    wr(8'h10, 32'h0);
    ci(1'h0);
    wr(8'h00, 32'h0);
    ci(1'h1);
    wr(8'h10, 32'h8);
    rc(8'h10, 32'h0);
    pulse(events_t'(7'h40));
    wr(8'h00, 32'h4);
    rc(8'h10, 32'h0);
    // Frozen clock enable drops the transmit start event
    ce <= 1'h0;
    pulse(events_t'(7'h40));
    ce <= 1'h1;
    rc(8'h10, 32'h0);
  endtask : t_begun

  task automatic t_done;
    wr(8'h00, 32'h40);
    wr(8'h14, 32'h1000);
    pulse(events_t'(7'h20));
    rc(8'h14, 32'h3000);
    ci(1'h0);
    wr(8'h14, 32'h3000);
    rc(8'h14, 32'h1000);
    ci(1'h1);
  endtask : t_done

  task automatic t_last;
    wr(8'h14, 32'h4000);
    pulse(events_t'(7'h10));
    rc(8'h00, 32'h40);
    pulse(events_t'(7'h18));
    rc(8'h00, 32'h2c0);
    wr(8'h00, 32'h240);
    rc(8'h00, 32'h40);
  endtask : t_last

  // Parity runs with the response enable low, then again high
  task automatic t_sys;
    wr(8'h14, 32'h400);
    wr(8'h00, 32'h0);
    for (int k = 0; k < 4; k++) begin
      pre <= k[0];
      pulse(events_t'((k == 3) ? 7'h4 : 7'h4 >> k));
      ci(1'h0);
      chk(32'(stp), 32'h1);
      rc(8'h14, 32'hc00);
      wr(8'h14, 32'hc00);
      rc(8'h14, 32'h400);
      ci(1'h1);
      wr(8'h00, 32'h0);
    end
  endtask : t_sys

  task automatic t_soft;
    wr(8'h10, 32'h400);
    wr(8'h14, 32'h5420);
    wr(8'h00, 32'h1);
    rc(8'h10, 32'h4);
    rc(8'h14, 32'h0);
    chk(32'(strip), 32'h0);
  endtask : t_soft

  task automatic t_wake;
    frame(sta, 16);
    cw(1'h1);
    rc(8'h18, 32'h1);
    wr(8'h18, 32'h1);
    cw(1'h0);
    frame(48'hffffffffffff, 16);
    cw(1'h0);
    wr(8'h14, 32'h20);
    frame(48'hffffffffffff, 16);
    cw(1'h1);
    wr(8'h18, 32'h41);
    wr(8'h14, 32'h0);
    frame(48'hffffffffffff, 16);
    cw(1'h1);
    wr(8'h18, 32'h41);
    frame(sta, 15);
    cw(1'h0);
  endtask : t_wake

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_bits;
    t_begun;
    t_done;
    t_last;
    t_sys;
    t_soft;
    t_wake;
    final_report;
  end

  // Whole run is under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report;
  end
endmodule : testbench
`default_nettype wire

// file: logic/ext_control_interrupt_bits.sv
// Purpose: Transmit, system and wake-frame interrupt bits behind APB
// Assumes: All inputs synchronous to sys_clk_in; events are one-cycle pulses
// Notes:   Zero-wait APB slave, unmapped words answer with pslverr
//
// Notes on behaviour
// - Frame transmit start sets tx begun flag
// - Tx begun irq needs global enable, mask clear
// - Tx begun flag: write one clears; resets, stop
// - Resets force tx begun mask; stop keeps
// - Auto strip removes pad and FCS
// - Resets clear auto strip; stop keeps
// - Obsolete bits ignore writes, read undefined
// - Transmitter finishing frame sets tx done
// - Tx done: write one clears; resets, stop
// - Tx done enable lets it raise summary
// - Parity, master or target abort sets sysirq
// - Parity error sets it regardless of response
// - System irq with enable drives interrupt
// - System irq ignores global enable
// - System irq: write one clears; stop keeps
// - System irq enable; resets clear, stop keeps
// - Accept bit widens wake destination match
// - Wake needs sixteen consecutive station addresses
// - Effective accept is OR of two bits
// - Resets clear wake accept; stop keeps
// - Indicator bits clear by writing ones
// - Global enable gates ordinary sources
//
// The APB register port and the register addresses were chosen for this implementation.
`include "ext_irq_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ext_control_interrupt_bits (
  // Clock, reset, enable
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  clk_en_in,
  // Register bus
  input  wire ext_irq_pkg::apb_req_t apb_req_in,
  output ext_irq_pkg::apb_rsp_t      apb_rsp_out,
  // Device events
  input  wire ext_irq_pkg::events_t  events_in,
  input  wire logic                  parity_response_enable_in,
  // Receive byte stream and station address
  input  wire ext_irq_pkg::rx_byte_t rx_byte_in,
  input  wire logic [47:0]           station_phys_addr_in,
  // Controls and interrupt
  output logic                       rx_auto_strip_out,
  output logic                       stop_out,
  output logic                       wake_frame_out,
  output logic                       irq_out_n
);
  import ext_irq_pkg::*;

  // Register state
  logic        global_irq_enable_q;
  logic        stop_q;
  logic        soft_reset_q;
  logic        tx_irq_q;
  logic        tx_begun_flag_q;
  logic        tx_begun_mask_q;
  logic        rx_auto_strip_q;
  logic        last_tx_irq_enable_q;
  logic        tx_done_irq_q;
  logic        tx_done_irq_enable_q;
  logic        system_error_irq_q;
  logic        system_error_irq_enable_q;
  logic        wake_frame_addr_accept_q;
  logic        wake_frame_addr_accept_ext_q;
  logic        wake_detected_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  // Bus decode, reset, stop, event and interrupt summary terms
  logic        wr_access;
  logic        setup_phase;
  logic        wr_main;
  logic        wr_feat;
  logic        wr_ext;
  logic        wr_wake;
  logic [31:0] wd;
  logic        clr_all;
  logic        stop_pulse;
  logic        sys_event;
  logic        ordinary_pending;
  logic        irq_summary;

  // Wake frame matcher
  wake_state_t wk_state_q;
  logic [2:0]  wk_pos_q;
  logic [4:0]  wk_copies_q;
  logic        dest_match_q;
  logic        wake_pulse;
  logic        accept_any;
  logic [7:0]  addr_byte;
  logic [7:0]  first_byte;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  function automatic logic [7:0] addr_byte_at(input logic [47:0] a, input logic [2:0] i);
    addr_byte_at = a[8 * i +: 8];
  endfunction : addr_byte_at

  assign wd          = apb_req_in.pwdata;
  assign setup_phase = apb_req_in.psel & ~apb_req_in.penable;
  assign wr_access   = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite & clk_en_in;
  assign wr_main     = wr_access & hit(apb_req_in.paddr, `OFS_MAIN_CTRL);
  assign wr_feat     = wr_access & hit(apb_req_in.paddr, `OFS_TEST_FEATURES);
  assign wr_ext      = wr_access & hit(apb_req_in.paddr, `OFS_EXT_CTRL_IRQ);
  assign wr_wake     = wr_access & hit(apb_req_in.paddr, `OFS_WAKE_CTRL);

  // Hardware reset or the self-clearing soft reset
  assign clr_all   = rst_in | soft_reset_q;
  // System error parity term ignores the parity response enable
  assign sys_event = events_in.pci_data_parity | events_in.pci_master_abort
                   | events_in.pci_target_abort;
  // A system error forces a stop, as does writing the stop bit
  assign stop_pulse = (wr_main & wd[`BIT_STOP]) | sys_event;

  // Main control: global enable, stop, soft reset
  always_ff @(posedge sys_clk_in) begin
    if (clr_all) begin
      global_irq_enable_q <= `RST_CLEAR;
      stop_q              <= 1'b1;
      soft_reset_q        <= `RST_CLEAR;
    end else if (clk_en_in) begin
      soft_reset_q <= wr_main & wd[`BIT_SOFT_RESET];
      if (stop_pulse) begin
        stop_q              <= 1'b1;
        global_irq_enable_q <= `RST_CLEAR;
      end else if (wr_main) begin
        stop_q              <= wd[`BIT_STOP];
        global_irq_enable_q <= wd[`BIT_GLOBAL_IRQ_EN];
      end
    end
  end

  // Transmit interrupt, qualified by the last-transmit descriptor flag
  always_ff @(posedge sys_clk_in) begin
    if (clr_all) begin
      tx_irq_q <= `RST_CLEAR;
    end else if (clk_en_in) begin
      if (events_in.frame_copied &
          (~last_tx_irq_enable_q | events_in.desc_last_tx_irq_flag)) begin
        tx_irq_q <= 1'b1;
      end else if (stop_pulse) begin
        tx_irq_q <= `RST_CLEAR;
      end else if (wr_main & wd[`BIT_TX_IRQ]) begin
        tx_irq_q <= `RST_CLEAR;
      end
    end
  end

  // Test and features: transmit start flag and mask, auto strip
  always_ff @(posedge sys_clk_in) begin
    if (clr_all) begin
      tx_begun_flag_q <= `RST_CLEAR;
      tx_begun_mask_q <= `RST_TX_BEGUN_MASK;
      rx_auto_strip_q <= `RST_CLEAR;
    end else if (clk_en_in) begin
      // Set wins over a clear in the same cycle
      if (events_in.tx_begin) begin
        tx_begun_flag_q <= 1'b1;
      end else if (stop_pulse) begin
        tx_begun_flag_q <= `RST_CLEAR;
      end else if (wr_feat & wd[`BIT_TX_BEGUN_FLAG]) begin
        tx_begun_flag_q <= `RST_CLEAR;
      end
      if (wr_feat) begin
        tx_begun_mask_q <= wd[`BIT_TX_BEGUN_MASK];
        rx_auto_strip_q <= wd[`BIT_RX_AUTO_STRIP];
      end
    end
  end

  // Extended control: enables that survive stop
  always_ff @(posedge sys_clk_in) begin
    if (clr_all) begin
      last_tx_irq_enable_q      <= `RST_CLEAR;
      tx_done_irq_enable_q      <= `RST_CLEAR;
      system_error_irq_enable_q <= `RST_CLEAR;
      wake_frame_addr_accept_q  <= `RST_CLEAR;
    end else if (clk_en_in && wr_ext) begin
      last_tx_irq_enable_q      <= wd[`BIT_LAST_TX_EN];
      tx_done_irq_enable_q      <= wd[`BIT_TX_DONE_EN];
      system_error_irq_enable_q <= wd[`BIT_SYS_IRQ_EN];
      wake_frame_addr_accept_q  <= wd[`BIT_WAKE_ACCEPT];
    end
  end

  // Transmission done indicator
  always_ff @(posedge sys_clk_in) begin
    if (clr_all) begin
      tx_done_irq_q <= `RST_CLEAR;
    end else if (clk_en_in) begin
      if (events_in.tx_done) begin
        tx_done_irq_q <= 1'b1;
      end else if (stop_pulse) begin
        tx_done_irq_q <= `RST_CLEAR;
      end else if (wr_ext & wd[`BIT_TX_DONE_IRQ]) begin
        tx_done_irq_q <= `RST_CLEAR;
      end
    end
  end

  // System error indicator; stop does not clear it, so it outlives the stop it causes
  always_ff @(posedge sys_clk_in) begin
    if (clr_all) begin
      system_error_irq_q <= `RST_CLEAR;
    end else if (clk_en_in) begin
      if (sys_event) begin
        system_error_irq_q <= 1'b1;
      end else if (wr_ext & wd[`BIT_SYS_IRQ]) begin
        system_error_irq_q <= `RST_CLEAR;
      end
    end
  end

  // Wake control: extension accept bit and detected indicator
  always_ff @(posedge sys_clk_in) begin
    if (clr_all) begin
      wake_frame_addr_accept_ext_q <= `RST_CLEAR;
      wake_detected_q              <= `RST_CLEAR;
    end else if (clk_en_in) begin
      if (wr_wake) begin
        wake_frame_addr_accept_ext_q <= wd[`BIT_WAKE_ACCEPT_EXT];
      end
      if (wake_pulse) begin
        wake_detected_q <= 1'b1;
      end else if (wr_wake & wd[`BIT_WAKE_DETECTED]) begin
        wake_detected_q <= `RST_CLEAR;
      end
    end
  end

  // Wake frame matcher over the receive byte stream
  assign accept_any = wake_frame_addr_accept_q | wake_frame_addr_accept_ext_q;
  assign addr_byte  = addr_byte_at(station_phys_addr_in, wk_pos_q);
  assign first_byte = addr_byte_at(station_phys_addr_in, 3'h0);
  assign wake_pulse = clk_en_in & rx_byte_in.valid & (wk_state_q == WK_PAYLOAD)
                    & dest_match_q & (wk_copies_q == `WAKE_COPIES - 5'h1)
                    & (wk_pos_q == `ADDR_BYTES - 3'h1) & (rx_byte_in.data == addr_byte);

  always_ff @(posedge sys_clk_in) begin
    if (clr_all) begin
      wk_state_q   <= WK_IDLE;
      wk_pos_q     <= 3'h0;
      wk_copies_q  <= 5'h0;
      dest_match_q <= `RST_CLEAR;
    end else if (clk_en_in && rx_byte_in.valid) begin
      if (rx_byte_in.sof) begin
        // Destination byte 0; broadcast and multicast pass only with accept
        wk_state_q   <= WK_DEST;
        wk_pos_q     <= 3'h1;
        wk_copies_q  <= 5'h0;
        dest_match_q <= accept_any | (rx_byte_in.data == first_byte);
      end else if (rx_byte_in.eof) begin
        wk_state_q <= WK_IDLE;
      end else begin
        case (wk_state_q)
          WK_DEST: begin
            dest_match_q <= dest_match_q & (accept_any | (rx_byte_in.data == addr_byte));
            if (wk_pos_q == `ADDR_BYTES - 3'h1) begin
              wk_state_q <= WK_PAYLOAD;
              wk_pos_q   <= 3'h0;
            end else begin
              wk_pos_q <= wk_pos_q + 3'h1;
            end
          end
          WK_PAYLOAD: begin
            // A broken run restarts, possibly on this very byte
            if (rx_byte_in.data == addr_byte) begin
              if (wk_pos_q == `ADDR_BYTES - 3'h1) begin
                wk_pos_q    <= 3'h0;
                wk_copies_q <= (wk_copies_q == `WAKE_COPIES - 5'h1) ? 5'h0 : wk_copies_q + 5'h1;
              end else begin
                wk_pos_q <= wk_pos_q + 3'h1;
              end
            end else begin
              wk_copies_q <= 5'h0;
              wk_pos_q    <= (rx_byte_in.data == first_byte) ? 3'h1 : 3'h0;
            end
          end
          default: begin
            wk_pos_q <= 3'h0;
          end
        endcase
      end
    end
  end

  // Interrupt summary and output
  assign ordinary_pending = (tx_begun_flag_q & ~tx_begun_mask_q)
                          | (tx_done_irq_q & tx_done_irq_enable_q)
                          | tx_irq_q;
  assign irq_summary = ordinary_pending
                     | (system_error_irq_q & system_error_irq_enable_q);
  // System error term bypasses the global enable, which its own stop clears
  assign irq_out_n = ~((ordinary_pending & global_irq_enable_q)
                     | (system_error_irq_q & system_error_irq_enable_q));

  // Read data captured in the setup phase; obsolete bits read zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (clk_en_in && setup_phase) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
      case (apb_req_in.paddr)
        `OFS_MAIN_CTRL: begin
          prdata_q[`BIT_STOP]          <= stop_q;
          prdata_q[`BIT_GLOBAL_IRQ_EN] <= global_irq_enable_q;
          prdata_q[`BIT_IRQ_SUMMARY]   <= irq_summary;
          prdata_q[`BIT_TX_IRQ]        <= tx_irq_q;
        end
        `OFS_TEST_FEATURES: begin
          prdata_q[`BIT_TX_BEGUN_MASK] <= tx_begun_mask_q;
          prdata_q[`BIT_TX_BEGUN_FLAG] <= tx_begun_flag_q;
          prdata_q[`BIT_RX_AUTO_STRIP] <= rx_auto_strip_q;
        end
        `OFS_EXT_CTRL_IRQ: begin
          prdata_q[`BIT_WAKE_ACCEPT] <= wake_frame_addr_accept_q;
          prdata_q[`BIT_SYS_IRQ_EN]  <= system_error_irq_enable_q;
          prdata_q[`BIT_SYS_IRQ]     <= system_error_irq_q;
          prdata_q[`BIT_TX_DONE_EN]  <= tx_done_irq_enable_q;
          prdata_q[`BIT_TX_DONE_IRQ] <= tx_done_irq_q;
          prdata_q[`BIT_LAST_TX_EN]  <= last_tx_irq_enable_q;
        end
        `OFS_WAKE_CTRL: begin
          prdata_q[`BIT_WAKE_DETECTED]   <= wake_detected_q;
          prdata_q[`BIT_WAKE_ACCEPT_EXT] <= wake_frame_addr_accept_ext_q;
        end
        default: begin
          pslverr_q <= 1'b1;
        end
      endcase
    end
  end

  assign apb_rsp_out.pready  = 1'b1;
  assign apb_rsp_out.pslverr = pslverr_q & apb_req_in.psel & apb_req_in.penable;
  assign apb_rsp_out.prdata  = prdata_q;

  assign rx_auto_strip_out = rx_auto_strip_q;
  assign stop_out          = stop_q;
  assign wake_frame_out    = wake_detected_q;

endmodule : ext_control_interrupt_bits
`default_nettype wire

// file: logic/ext_irq_defs.svh
// Purpose: Offsets, bit positions and reset values of the interrupt bits
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Definitions only
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// Byte offsets
`define OFS_MAIN_CTRL      8'h00
`define OFS_TEST_FEATURES  8'h10
`define OFS_EXT_CTRL_IRQ   8'h14
`define OFS_WAKE_CTRL      8'h18

// Main control register bits
`define BIT_SOFT_RESET     0
`define BIT_STOP           2
`define BIT_GLOBAL_IRQ_EN  6
`define BIT_IRQ_SUMMARY    7
`define BIT_TX_IRQ         9

// Test and features register bits
`define BIT_TX_BEGUN_MASK  2
`define BIT_TX_BEGUN_FLAG  3
`define BIT_RX_AUTO_STRIP  10

// Extended control and interrupt register bits
`define BIT_WAKE_ACCEPT    5
`define BIT_SYS_IRQ_EN     10
`define BIT_SYS_IRQ        11
`define BIT_TX_DONE_EN     12
`define BIT_TX_DONE_IRQ    13
`define BIT_LAST_TX_EN     14

// Wake control register bits
`define BIT_WAKE_DETECTED  0
`define BIT_WAKE_ACCEPT_EXT 6

// Reset values
`define RST_TX_BEGUN_MASK  1'b1
`define RST_CLEAR          1'b0

// Wake frame figures
`define WAKE_COPIES        5'h10
`define ADDR_BYTES         3'h6

`endif

// file: logic/ext_irq_pkg.sv
// Purpose: Types shared by the interrupt bit block
// Assumes: APB with 32-bit data
// Notes:   Constants live in ext_irq_defs.svh
`default_nettype none
package ext_irq_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic tx_begin;
    logic tx_done;
    logic frame_copied;
    logic desc_last_tx_irq_flag;
    logic pci_data_parity;
    logic pci_master_abort;
    logic pci_target_abort;
  } events_t;

  typedef struct packed {
    logic       sof;
    logic       valid;
    logic       eof;
    logic [7:0] data;
  } rx_byte_t;

  typedef enum logic [1:0] {
    WK_IDLE,
    WK_DEST,
    WK_PAYLOAD
  } wake_state_t;

endpackage : ext_irq_pkg
`default_nettype wire
